// *** verilog/tpc_pkg.sv ***
// shared constants and types of the transceiver pin control block
package tpc_pkg;
   // clock and bit timing
   localparam int CLK_NS = 50;                   // sys_clk period in ns
   localparam int BIT_NS = 1000;                 // serial bit time in ns
   localparam int BIT_CYC = BIT_NS / CLK_NS;     // cycles per bit
   localparam logic [4:0] BIT_LAST = 5'(BIT_CYC - 1);
   localparam logic [4:0] HALF_PT = 5'(BIT_CYC / 2);
   // data path sizes
   localparam int DAT_W = 8;
   localparam int FIFO_D = 32;
   // readback vector layout, then extra synchronised inputs
   localparam int RB_PE = 0;
   localparam int RB_LED = 3;
   localparam int RB_RES = 5;
   localparam int RB_SD = 12;
   localparam int RB_USR = 17;
   localparam int RB_W = 18;
   localparam int S_LOCK = 18;
   localparam int S_RXD = 19;
   localparam int S_RXC = 20;
   localparam int SYNC_W = 21;
   // idle level choices for the transmit data pin
   localparam logic [1:0] IDLE_ZERO = 2'h0;
   localparam logic [1:0] IDLE_ONE = 2'h1;
   localparam logic [1:0] IDLE_LAST = 2'h2;
   // values after reset
   localparam logic [2:0] PE_RST = 3'h7;
   localparam logic [1:0] LED_RST = 2'h3;
   localparam logic [4:0] CNT_RST = 5'h00;
   // transmit sequencer states
   typedef enum logic [1:0] {TX_IDLE, TX_UP, TX_DATA, TX_DOWN} tpc_tx_st_t;
endpackage

// *** verilog/tpc_stream_if.sv ***
// byte stream carrier with valid and ready between block modules
`timescale 1ns/1ps
interface tpc_stream_if #(parameter int W = 8);
   logic [W-1:0] data;   // payload
   logic valid;          // source offers data
   logic ready;          // sink takes data
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// *** verilog/tpc_fifo.sv ***
// parameterised first-in first-out buffer for the transmit bytes
`timescale 1ns/1ps
module tpc_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // streams
   tpc_stream_if.snk wr,
   tpc_stream_if.src rd
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;  // write pointer
      logic [AW-1:0] rp;  // read pointer
      logic [AW:0] cnt;   // words held
      logic nfull;        // room left, registered
   } tpc_fifo_st_t;
   tpc_fifo_st_t st_reg, st_next;
   logic [W-1:0] mem [D];  // storage
   logic push, pop;

   // next pointers and fill level
   always_comb begin
      push = wr.valid && st_reg.nfull;
      pop = rd.ready && (st_reg.cnt != '0);
      st_next = st_reg;
      if (push) begin
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (pop) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
      st_next.nfull = st_next.cnt != (AW+1)'(D);
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '{wp: '0, rp: '0, cnt: '0, nfull: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   // storage write, no reset needed
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[st_reg.wp] <= wr.data;
      end
   end

   assign wr.ready = st_reg.nfull;
   assign rd.valid = st_reg.cnt != '0;
   assign rd.data = mem[st_reg.rp];

   fifo_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      st_reg.cnt <= (AW+1)'(D) && (st_reg.nfull == (st_reg.cnt != (AW+1)'(D))))
      else $error("fifo level out of range");
   fifo_full_c: cover property (@(posedge clk_i) disable iff (rst_i) !st_reg.nfull);
endmodule // tpc_fifo

// *** verilog/tpc_pin_ctrl.sv ***
// transceiver pin control: reference clocks, strobes, serial paths, loose pins
`timescale 1ns/1ps
// What this block does
// - high reference clock full or half rate
// - low reference clock full or half rate
// - high reference clock low while unpowered
// - low reference clock low while unpowered
// - power enables active low, bidirectional, readable
// - synth lock level readable by software
// - receive bit clock recovered from data
// - external mode samples on receive clock rise
// - command from sequencer or bit, programmable
// - card-bus complementary command output
// - modulation enable from sequencer, programmable polarity
// - amplifier enable from sequencer, programmable polarity
// - data changes on falling bit clock
// - idle data level zero, one or last
// - complementary data reads zero when idle
// - LED pins open drain, readable, drive high
// - one analog source selected at once
// - result pins converter, register or bidirectional
// - serial device pins bit-banged with readback
// - sleep indicator high in power down
// - user pin direction and value set
module tpc_pin_ctrl (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // configuration
   input wire logic clock_halve_select_i,
   input wire logic cardbus_mode_i,
   input wire logic external_recovery_select_i,
   input wire logic rx_enable_i,
   input wire logic [1:0] idle_level_sel_i,
   input wire logic [7:0] ramp_up_cycles_i,
   input wire logic [7:0] ramp_down_cycles_i,
   input wire logic [2:0] strobe_invert_i,
   input wire logic [2:0] strobe_force_i,
   input wire logic power_down_i,
   // power enable pins: 0 high freq, 1 low freq, 2 receive
   input wire logic [2:0] power_enable_val_i,
   input wire logic [2:0] power_enable_dir_i,
   input wire logic [2:0] power_enable_in_i,
   output logic [2:0] power_enable_o,
   output logic [2:0] power_enable_oe_o,
   // synthesizer reference clocks and lock
   output logic high_synth_ref_clock_o,
   output logic low_synth_ref_clock_o,
   input wire logic synth_lock_input_i,
   output logic synth_lock_o,
   // receive path
   input wire logic serial_receive_input_i,
   input wire logic external_receive_clock_i,
   output logic [tpc_pkg::DAT_W-1:0] rx_byte_o,
   output logic rx_byte_valid_o,
   // transmit data stream
   input wire logic [tpc_pkg::DAT_W-1:0] tx_byte_i,
   input wire logic tx_byte_valid_i,
   output logic tx_byte_ready_o,
   input wire logic tx_frame_i,
   // transmit pins
   output logic transmit_command_o,
   output logic transmit_command_n_o,
   output logic modulation_enable_o,
   output logic transmit_amp_enable_o,
   output logic serial_transmit_output_o,
   output logic serial_transmit_n_o,
   output logic transmit_bit_clock_o,
   // LED pins: 0 traffic, 1 link
   input wire logic [1:0] led_on_i,
   input wire logic [1:0] led_drive_high_i,
   input wire logic [1:0] led_in_i,
   output logic [1:0] led_o,
   output logic [1:0] led_oe_o,
   // converter source and result pins
   input wire logic analog_source_sel_i,
   output logic analog_source_select_o,
   input wire logic [6:0] converter_value_i,
   input wire logic result_reg_mode_i,
   input wire logic [6:0] result_val_i,
   input wire logic [6:0] result_dir_i,
   input wire logic [6:0] converter_result_in_i,
   output logic [6:0] converter_result_pins_o,
   output logic [6:0] converter_result_oe_o,
   // serial device pins: 0 clock, 1 line, 4:2 selects
   input wire logic [4:0] serial_device_val_i,
   input wire logic [4:0] serial_device_dir_i,
   input wire logic [4:0] serial_device_in_i,
   output logic [4:0] serial_device_o,
   output logic [4:0] serial_device_oe_o,
   // user pin eight
   input wire logic user_pin_eight_val_i,
   input wire logic user_pin_eight_dir_i,
   input wire logic user_pin_eight_in_i,
   output logic user_pin_eight_o,
   output logic user_pin_eight_oe_o,
   // sleep indicator and pin readback
   output logic sleep_indicator_o,
   output logic [tpc_pkg::RB_W-1:0] pin_readback_o
);
   import tpc_pkg::*;

   // all block state
   typedef struct packed {
      logic [SYNC_W-1:0] sy1;   // first synchroniser stage
      logic [SYNC_W-1:0] sy2;   // second synchroniser stage
      logic rxc_d;              // delayed receive clock for edge find
      logic rx_prev;            // last receive level
      logic [4:0] rx_cnt;       // recovery phase counter
      logic [7:0] rx_sh;        // receive shifter
      logic [2:0] rx_n;         // receive bit count
      logic rx_vld;             // byte strobe
      logic [7:0] rx_byte;      // assembled byte
      logic div;                // divide-by-two phase
      logic hf;                 // high reference clock
      logic lf;                 // low reference clock
      tpc_tx_st_t st;           // transmit sequencer
      logic [7:0] tcnt;         // ramp counter
      logic [4:0] bcnt;         // phase within bit
      logic [2:0] bitn;         // bit within byte
      logic [7:0] sh;           // transmit shifter
      logic last;               // last bit sent
      logic txd;                // transmit data pin
      logic txd_n;              // complementary data pin
      logic transmit_bit_clock;                // transmit bit clock pin
      logic cmd;                // command pin
      logic cmd_n;              // complementary command pin
      logic mod;                // modulation pin
      logic amp;                // amplifier pin
      logic [2:0] pe;           // power enable values
      logic [2:0] pe_oe;        // power enable drives
      logic [1:0] led;          // LED values
      logic [1:0] led_oe;       // LED drives
      logic [6:0] res;          // result pin values
      logic [6:0] res_oe;       // result pin drives
      logic [4:0] sd;           // serial device values
      logic [4:0] sd_oe;        // serial device drives
      logic usr;                // user pin value
      logic usr_oe;             // user pin drive
      logic src;                // analog source
      logic slp;                // sleep indicator
      logic [RB_W-1:0] rb;      // readback register
      logic lock;               // lock readback
   } tpc_st_t;

   tpc_st_t s_reg, s_next;
   logic fetch;       // pop one byte from the buffer
   logic smp;         // take one receive sample
   logic rxd, rxc;    // synchronised receive pins

   tpc_stream_if #(.W(DAT_W)) wr_if ();
   tpc_stream_if #(.W(DAT_W)) rd_if ();

   // active-low pin level from an active flag and a polarity swap
   function automatic logic drv(input logic act, input logic inv);
      return (~act) ^ inv;
   endfunction

   // the transmit buffer absorbs bursts; full stalls the source
   tpc_fifo #(.W(DAT_W), .D(FIFO_D)) u_fifo (
      .clk_i(sys_clk_i),
      .rst_i(reset_i),
      .wr(wr_if.snk),
      .rd(rd_if.src)
   );

   assign wr_if.data = tx_byte_i;
   assign wr_if.valid = tx_byte_valid_i;
   assign rd_if.ready = fetch;

   // next state of the whole block
   always_comb begin
      s_next = s_reg;
      fetch = 1'b0;
      smp = 1'b0;
      // every input pin level passes two flops before use; configuration and stream inputs are used directly
      s_next.sy1 = {external_receive_clock_i, serial_receive_input_i,
                    synth_lock_input_i, user_pin_eight_in_i, serial_device_in_i,
                    converter_result_in_i, led_in_i, power_enable_in_i};
      s_next.sy2 = s_reg.sy1;
      rxd = s_reg.sy2[S_RXD];
      rxc = s_reg.sy2[S_RXC];
      s_next.rb = s_reg.sy2[RB_W-1:0];
      s_next.lock = s_reg.sy2[S_LOCK];

      // register-driven pins
      s_next.pe = power_enable_val_i;
      s_next.pe_oe = power_enable_dir_i;
      // open drain: pull low when lit, drive high only if asked
      s_next.led = ~led_on_i;
      s_next.led_oe = led_on_i | led_drive_high_i;
      if (result_reg_mode_i) begin
         s_next.res = result_val_i;
         s_next.res_oe = result_dir_i;
      end else begin
         s_next.res = converter_value_i;
         s_next.res_oe = '1;
      end
      s_next.sd = serial_device_val_i;
      s_next.sd_oe = serial_device_dir_i;
      s_next.usr = user_pin_eight_val_i;
      s_next.usr_oe = user_pin_eight_dir_i;
      s_next.src = analog_source_sel_i;
      s_next.slp = power_down_i;

      // reference clocks: toggle each cycle, or each second cycle
      s_next.div = ~s_reg.div;
      if (s_next.pe[0]) begin
         s_next.hf = 1'b0;
      end else if (!clock_halve_select_i || s_reg.div) begin
         s_next.hf = ~s_reg.hf;
      end
      if (s_next.pe[1]) begin
         s_next.lf = 1'b0;
      end else if (!clock_halve_select_i || s_reg.div) begin
         s_next.lf = ~s_reg.lf;
      end

      // receive sampling point: external clock edge or recovered phase
      s_next.rxc_d = rxc;
      s_next.rx_prev = rxd;
      if (external_recovery_select_i) begin
         smp = rxc && !s_reg.rxc_d;
      end else begin
         // data edges re-centre the phase; sample at mid bit
         if (rxd != s_reg.rx_prev) begin
            s_next.rx_cnt = CNT_RST;
         end else if (s_reg.rx_cnt == BIT_LAST) begin
            s_next.rx_cnt = CNT_RST;
         end else begin
            s_next.rx_cnt = s_reg.rx_cnt + 5'h01;
         end
         smp = (s_reg.rx_cnt == HALF_PT);
      end
      // bytes assemble least significant bit first
      s_next.rx_vld = 1'b0;
      if (!rx_enable_i) begin
         s_next.rx_n = 3'h0;
      end else if (smp) begin
         s_next.rx_sh = {rxd, s_reg.rx_sh[7:1]};
         s_next.rx_n = s_reg.rx_n + 3'h1;
         if (s_reg.rx_n == 3'h7) begin
            s_next.rx_byte = {rxd, s_reg.rx_sh[7:1]};
            s_next.rx_vld = 1'b1;
         end
      end

      // transmit sequencer
      case (s_reg.st)
         TX_IDLE: begin
            // a frame starts only with a byte waiting
            if (tx_frame_i && rd_if.valid) begin
               s_next.st = TX_UP;
               s_next.tcnt = ramp_up_cycles_i;
            end
         end
         TX_UP: begin
            if (s_reg.tcnt == 8'h00) begin
               s_next.st = TX_DATA;
               fetch = 1'b1;
               s_next.sh = rd_if.data;
               s_next.bcnt = CNT_RST;
               s_next.bitn = 3'h0;
            end else begin
               s_next.tcnt = s_reg.tcnt - 8'h01;
            end
         end
         TX_DATA: begin
            // new bit leaves with the falling bit clock
            if (s_reg.bcnt == CNT_RST) begin
               s_next.txd = s_reg.sh[0];
               s_next.last = s_reg.sh[0];
               s_next.transmit_bit_clock = 1'b0;
            end else if (s_reg.bcnt == HALF_PT) begin
               s_next.transmit_bit_clock = 1'b1;
            end
            if (s_reg.bcnt == BIT_LAST) begin
               s_next.bcnt = CNT_RST;
               s_next.sh = {1'b0, s_reg.sh[7:1]};
               s_next.bitn = s_reg.bitn + 3'h1;
               if (s_reg.bitn == 3'h7) begin
                  // an empty buffer ends the frame
                  if (rd_if.valid) begin
                     fetch = 1'b1;
                     s_next.sh = rd_if.data;
                  end else begin
                     s_next.st = TX_DOWN;
                     s_next.tcnt = ramp_down_cycles_i;
                  end
               end
            end else begin
               s_next.bcnt = s_reg.bcnt + 5'h01;
            end
         end
         TX_DOWN: begin
            if (s_reg.tcnt == 8'h00) begin
               s_next.st = TX_IDLE;
            end else begin
               s_next.tcnt = s_reg.tcnt - 8'h01;
            end
         end
         default: begin
            s_next.st = TX_IDLE;
         end
      endcase

      // idle and ramp level of the data pin
      if (s_next.st != TX_DATA) begin
         s_next.transmit_bit_clock = 1'b1;
         case (idle_level_sel_i)
            IDLE_ZERO: s_next.txd = 1'b0;
            IDLE_ONE: s_next.txd = 1'b1;
            IDLE_LAST: s_next.txd = s_reg.last;
            default: s_next.txd = 1'b0;
         endcase
      end
      // complement only exists in card-bus form and rests at zero
      s_next.txd_n = cardbus_mode_i && (s_next.st == TX_DATA) && !s_next.txd;

      // strobes: sequencer term or software force, then polarity
      s_next.cmd = drv((s_next.st != TX_IDLE) || strobe_force_i[0],
                       strobe_invert_i[0]);
      s_next.mod = drv((s_next.st == TX_DATA) || strobe_force_i[1],
                       strobe_invert_i[1]);
      s_next.amp = drv((s_next.st != TX_IDLE) || strobe_force_i[2],
                       strobe_invert_i[2]);
      s_next.cmd_n = cardbus_mode_i && !s_next.cmd;
   end

   // state register; pins come up inactive
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s_reg <= '{st: TX_IDLE, transmit_bit_clock: 1'b1, cmd: 1'b1, mod: 1'b1, amp: 1'b1,
                    pe: PE_RST, pe_oe: PE_RST, led: LED_RST, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state register; byte ready straight from the buffer's room flag
   assign power_enable_o = s_reg.pe;
   assign power_enable_oe_o = s_reg.pe_oe;
   assign high_synth_ref_clock_o = s_reg.hf;
   assign low_synth_ref_clock_o = s_reg.lf;
   assign synth_lock_o = s_reg.lock;
   assign rx_byte_o = s_reg.rx_byte;
   assign rx_byte_valid_o = s_reg.rx_vld;
   assign tx_byte_ready_o = wr_if.ready;
   assign transmit_command_o = s_reg.cmd;
   assign transmit_command_n_o = s_reg.cmd_n;
   assign modulation_enable_o = s_reg.mod;
   assign transmit_amp_enable_o = s_reg.amp;
   assign serial_transmit_output_o = s_reg.txd;
   assign serial_transmit_n_o = s_reg.txd_n;
   assign transmit_bit_clock_o = s_reg.transmit_bit_clock;
   assign led_o = s_reg.led;
   assign led_oe_o = s_reg.led_oe;
   assign analog_source_select_o = s_reg.src;
   assign converter_result_pins_o = s_reg.res;
   assign converter_result_oe_o = s_reg.res_oe;
   assign serial_device_o = s_reg.sd;
   assign serial_device_oe_o = s_reg.sd_oe;
   assign user_pin_eight_o = s_reg.usr;
   assign user_pin_eight_oe_o = s_reg.usr_oe;
   assign sleep_indicator_o = s_reg.slp;
   assign pin_readback_o = s_reg.rb;

   // checks on the pins
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   hf_gate_a: assert property (power_enable_o[0] |-> !high_synth_ref_clock_o)
      else $error("high reference clock runs while unpowered");
   lf_gate_a: assert property (power_enable_o[1] |-> !low_synth_ref_clock_o)
      else $error("low reference clock runs while unpowered");
   hf_rate_a: assert property (
      (!power_enable_o[0] && !$past(power_enable_o[0]) && !$past(clock_halve_select_i))
      |-> high_synth_ref_clock_o != $past(high_synth_ref_clock_o))
      else $error("high reference clock not at full rate");
   lf_rate_a: assert property (
      (!power_enable_o[1] && !$past(power_enable_o[1]) && !$past(power_enable_o[1], 2)
       && $past(clock_halve_select_i) && $past(clock_halve_select_i, 2))
      |-> low_synth_ref_clock_o != $past(low_synth_ref_clock_o, 2))
      else $error("low reference clock not at half rate");
   cmd_compl_a: assert property (cardbus_mode_i && $past(cardbus_mode_i)
      |-> transmit_command_n_o == !transmit_command_o)
      else $error("complementary command not inverse");
   idle_zero_a: assert property (
      (s_reg.st != TX_DATA && $past(idle_level_sel_i) == IDLE_ZERO)
      |-> !serial_transmit_output_o)
      else $error("idle data not zero");
   compl_idle_a: assert property ((s_reg.st != TX_DATA) |-> !serial_transmit_n_o)
      else $error("complementary data not zero when idle");
   txc_fall_a: assert property (
      (s_reg.st == TX_DATA && $past(s_reg.st) == TX_DATA
       && $changed(serial_transmit_output_o)) |-> !transmit_bit_clock_o)
      else $error("data changed without falling bit clock");
   mod_data_a: assert property (
      (s_reg.st == TX_DATA) |-> modulation_enable_o == $past(strobe_invert_i[1]))
      else $error("modulation not active in data");
   lock_read_a: assert property (
      (!$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3))
      |-> synth_lock_o == $past(synth_lock_input_i, 3))
      else $error("lock readback wrong");
   rst_idle_a: assert property ($past(reset_i) |->
      power_enable_o == PE_RST && transmit_command_o && transmit_amp_enable_o)
      else $error("pins not inactive after reset");

   frame_c: cover property (s_reg.st == TX_DATA ##1 s_reg.st == TX_DOWN);
   rx_byte_c: cover property (rx_byte_valid_o && external_recovery_select_i);
   rx_rec_c: cover property (rx_byte_valid_o && !external_recovery_select_i);
   busy_c: cover property (!tx_byte_ready_o && s_reg.st == TX_DATA);
endmodule // tpc_pin_ctrl

// *** verif/tpc_xcvr_model.sv ***
// transceiver partner: sends receive bits on its own clock, captures transmit bits
`timescale 1ns/1ps
module tpc_xcvr_model (
   // clock
   input wire logic sys_clk_i,
   // transmit side pins
   input wire logic txd_i,
   input wire logic txc_i,
   input wire logic cmd_i,
   // receive side pins
   output logic rxd_o,
   output logic rxc_o,
   // last byte captured
   output logic [7:0] tx_cap_o
);
   // receive clock stands still outside bytes
   initial {rxd_o, rxc_o} = 2'h0;
   // transmitter keyed only while command low, lsb lands at the bottom
   always @(posedge txc_i) if (cmd_i === 1'b0) tx_cap_o <= {txd_i, tx_cap_o[7:1]};
   // one byte lsb first, data set a half bit before the rising clock
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         rxd_o = b[i];
         repeat (10) @(posedge sys_clk_i);
         #5 rxc_o = 1'b1;
         repeat (10) @(posedge sys_clk_i);
         #5 rxc_o = 1'b0;
      end
      rxd_o = ~b[7]; // line driven to the inverse of the last bit, stale level not kept
   endtask
endmodule // tpc_xcvr_model

// *** verif/test_tpc_pin_ctrl.sv ***
// self-checking bench for the transceiver pin control block
`timescale 1ns/1ps
module test_tpc_pin_ctrl;
   import tpc_pkg::*;
   // design pins, named as the ports
   logic sys_clk_i = 0, reset_i = 1, clock_halve_select_i, cardbus_mode_i, rx_enable_i;
   logic external_recovery_select_i, tx_byte_valid_i, tx_frame_i, power_down_i;
   logic synth_lock_input_i, serial_receive_input_i, external_receive_clock_i;
   logic analog_source_sel_i, result_reg_mode_i, user_pin_eight_val_i, user_pin_eight_dir_i;
   logic user_pin_eight_in_i, high_synth_ref_clock_o, low_synth_ref_clock_o, synth_lock_o;
   logic rx_byte_valid_o, tx_byte_ready_o, transmit_command_o, transmit_command_n_o;
   logic modulation_enable_o, transmit_amp_enable_o, serial_transmit_output_o;
   logic serial_transmit_n_o, transmit_bit_clock_o, analog_source_select_o;
   logic user_pin_eight_o, user_pin_eight_oe_o, sleep_indicator_o;
   logic [1:0] idle_level_sel_i, led_on_i, led_drive_high_i, led_in_i, led_o, led_oe_o;
   logic [7:0] ramp_up_cycles_i, ramp_down_cycles_i, tx_byte_i, rx_byte_o, cap;
   logic [2:0] strobe_invert_i, strobe_force_i, power_enable_val_i, power_enable_dir_i;
   logic [2:0] power_enable_in_i, power_enable_o, power_enable_oe_o;
   logic [6:0] converter_value_i, result_val_i, result_dir_i, converter_result_in_i;
   logic [6:0] converter_result_pins_o, converter_result_oe_o;
   logic [4:0] serial_device_val_i, serial_device_dir_i, serial_device_in_i;
   logic [4:0] serial_device_o, serial_device_oe_o;
   logic [RB_W-1:0] pin_readback_o;
   int n_mismatch = 0, n_tests = 0, hc, lc, nrx = 0;
   // 20 MHz clock
   always #25 sys_clk_i = ~sys_clk_i;
   tpc_pin_ctrl uut (.*);
   tpc_xcvr_model xm (.sys_clk_i, .txd_i(serial_transmit_output_o),
      .txc_i(transmit_bit_clock_o), .cmd_i(transmit_command_o),
      .rxd_o(serial_receive_input_i), .rxc_o(external_receive_clock_i), .tx_cap_o(cap));
   // count receive strobes, each one cycle wide
   always @(posedge sys_clk_i) if (rx_byte_valid_o === 1'b1) nrx++;
   // inputs move a fixed 5 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #5;
   endtask
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // bounded wait for a design output level
   task automatic wait_for(ref logic s, input logic v);
      for (int i = 0; i < 400 && s !== v; i++) cyc(1);
      if (s !== v) chk(s, v);
   endtask
   // level changes of both reference clocks over 8 cycles
   task automatic edges;
      logic h;
      logic l;
      hc = 0;
      lc = 0;
      for (int i = 0; i < 8; i++) begin
         h = high_synth_ref_clock_o;
         l = low_synth_ref_clock_o;
         cyc(1);
         hc += (h !== high_synth_ref_clock_o);
         lc += (l !== low_synth_ref_clock_o);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // watchdog, the tests need about 600 cycles
   initial begin
      #2000000;
      n_mismatch++;
      final_report();
   end
   initial begin
      {clock_halve_select_i, cardbus_mode_i, external_recovery_select_i, rx_enable_i} = 4'h0;
      {tx_byte_valid_i, tx_frame_i, power_down_i, synth_lock_input_i} = 4'h0;
      {analog_source_sel_i, result_reg_mode_i, user_pin_eight_val_i} = 3'h0;
      {user_pin_eight_dir_i, user_pin_eight_in_i, power_enable_val_i} = {2'h0, 3'h7};
      {idle_level_sel_i, led_on_i, led_drive_high_i, led_in_i} = 8'h00;
      {ramp_up_cycles_i, ramp_down_cycles_i, tx_byte_i} = {8'h04, 8'h03, 8'h00};
      {strobe_invert_i, strobe_force_i, power_enable_dir_i, power_enable_in_i} = 12'h000;
      {converter_value_i, result_val_i, result_dir_i, converter_result_in_i} = 28'h0000000;
      {serial_device_val_i, serial_device_dir_i, serial_device_in_i} = 15'h0000;
      cyc(12);
      reset_i = 1'b0;
      chk({power_enable_o, led_o, led_oe_o, transmit_command_o, modulation_enable_o,
         transmit_amp_enable_o}, {3'h7, 2'h3, 2'h0, 3'h7});
      $display("reset test done");
      // full then half rate with both supplies on, then gated off
      for (int k = 0; k < 2; k++) begin
         {clock_halve_select_i, power_enable_val_i} = {k[0], 3'h4};
         cyc(3);
         edges();
         chk(hc, k ? 4 : 8);
         chk(lc, k ? 4 : 8);
         power_enable_val_i = 3'h7;
         cyc(3);
         edges();
         chk({high_synth_ref_clock_o, low_synth_ref_clock_o, 16'(hc + lc)}, 18'h0);
      end
      $display("reference clock test done");
      {power_enable_dir_i, power_enable_in_i, led_on_i, led_drive_high_i, led_in_i} =
         {3'h5, 3'h6, 2'h1, 2'h2, 2'h2};
      {serial_device_val_i, serial_device_dir_i, serial_device_in_i} = {5'h15, 5'h0C, 5'h1A};
      {user_pin_eight_val_i, user_pin_eight_dir_i, user_pin_eight_in_i} = 3'h7;
      {result_reg_mode_i, result_val_i, result_dir_i, converter_result_in_i} =
         {1'h1, 7'h2A, 7'h0F, 7'h55};
      {power_down_i, analog_source_sel_i, synth_lock_input_i, converter_value_i} = {3'h7, 7'h33};
      cyc(4);
      chk({power_enable_oe_o, led_o, led_oe_o}, {3'h5, 2'h2, 2'h3});
      chk({serial_device_o, serial_device_oe_o, user_pin_eight_o, user_pin_eight_oe_o},
         {5'h15, 5'h0C, 2'h3});
      chk({converter_result_pins_o, converter_result_oe_o}, {7'h2A, 7'h0F});
      chk({sleep_indicator_o, analog_source_select_o, synth_lock_o}, 3'h7);
      chk(pin_readback_o, {1'h1, 5'h1A, 7'h55, 2'h2, 3'h6});
      result_reg_mode_i = 1'b0;
      cyc(2);
      chk({converter_result_pins_o, converter_result_oe_o}, {7'h33, 7'h7F});
      $display("loose pin test done");
      // one byte framed, last bit sent is 1
      {cardbus_mode_i, idle_level_sel_i, tx_byte_i, tx_byte_valid_i, tx_frame_i} =
         {1'h1, IDLE_LAST, 8'hA5, 2'h3};
      cyc(1);
      tx_byte_valid_i = 1'b0;
      wait_for(transmit_command_o, 1'b0);
      chk({transmit_command_o, transmit_command_n_o, transmit_amp_enable_o,
         modulation_enable_o, serial_transmit_n_o}, 5'h0A);
      wait_for(modulation_enable_o, 1'b0);
      chk({modulation_enable_o, transmit_amp_enable_o}, 2'h0);
      wait_for(transmit_command_o, 1'b1);
      {tx_frame_i, idle_level_sel_i} = {1'h0, IDLE_LAST};
      cyc(1);
      chk({cap, serial_transmit_output_o, serial_transmit_n_o, transmit_command_n_o},
         {8'hA5, 3'h4});
      for (int v = 0; v < 2; v++) begin
         idle_level_sel_i = v ? IDLE_ONE : IDLE_ZERO;
         cyc(2);
         chk({serial_transmit_output_o, serial_transmit_n_o}, {v[0], 1'b0});
      end
      $display("transmit test done");
      for (int m = 1; m >= 0; m--) begin
         {external_recovery_select_i, rx_enable_i} = {m[0], 1'b0};
         fork
            xm.send(m ? 8'hC3 : 8'h69);
            #150 rx_enable_i = 1'b1;
         join
         cyc(5);
         chk({rx_byte_o, 8'(nrx)}, {m ? 8'hC3 : 8'h69, 8'(2 - m)});
      end
      $display("receive test done");
      final_report();
   end
endmodule // test_tpc_pin_ctrl
